// ### hdl/tcss_target.sv
`timescale 1ns/1ns
`default_nettype none
module tcss_target #(
  parameter int BYTE_WIDTH = 8 // serial byte width
) (
  // system clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // link clock, the bus clock line itself
  input  wire logic                  linkClock,
  // bus pins, open drain
  input  wire logic                  sclIn,
  output logic                       sclOut,
  output logic                       sclOe_n,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe_n,
  // software control
  input  wire tcss_pkg::tcss_ctrl_t  ctrl,
  input  wire logic                  releaseSet,
  input  wire logic                  irqClear,
  input  wire logic                  bufferRead,
  input  wire logic                  txLoad,
  input  wire logic [7:0]            txData,
  input  wire logic                  ownAddrWrite,
  input  wire logic [7:0]            ownAddrData,
  // software status
  output tcss_pkg::tcss_status_t     status,
  output logic [7:0]                 rxData,
  output logic [7:0]                 ownAddress
);

  // only byte frames of eight bits are supported
  if (BYTE_WIDTH != 8) begin : gBadWidth
    $error("tcss_target: BYTE_WIDTH must be 8");
  end

  // link domain: bit sampled on scl rise, toggle marks event
  logic linkBit_q;
  logic linkToggle_q;
  // system domain synchronisers
  logic sclMeta, sclSync, sclPrev;
  logic sdaMeta, sdaSync, sdaPrev;
  logic tglMeta, tglSync, tglPrev;
  // byte sequencing state
  tcss_pkg::tcss_phase_t phase_q;
  logic [3:0] cnt_q;             // rising edges in frame
  logic [7:0] shift_q;           // received bits
  logic [7:0] txShift_q;         // bits to send
  logic       txValid_q;         // transmit byte loaded
  logic       ackWindow_q;       // we own the ack slot
  logic       ackUsesSw_q;       // ack value from software
  logic       tenMatched_q;      // full ten-bit address seen
  logic       sdaPull_q;         // registered sda pull
  logic       sclPull_q;         // registered scl pull
  // status flops
  logic       irq_q, rel_q, bf_q, ua_q, ack_timing_status_q, ackRx_q;
  logic       rw_q, dna_q, startSeen_q, stopSeen_q;
  logic [7:0] rxData_q, ownAddr_q;

  // capture sda on each scl rise and flag it by a toggle
  always_ff @(posedge linkClock or negedge reset_n) begin
    if (!reset_n) begin
      linkBit_q    <= 1'h0;
      linkToggle_q <= 1'h0;
    end else begin
      linkBit_q    <= sdaIn;
      linkToggle_q <= ~linkToggle_q;
    end
  end

  // two-flop synchronisers plus one history stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {sclMeta, sclSync, sclPrev} <= 3'h7;
      {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
      {tglMeta, tglSync, tglPrev} <= 3'h0;
    end else begin
      {sclMeta, sclSync, sclPrev} <= {sclIn, sclMeta, sclSync};
      {sdaMeta, sdaSync, sdaPrev} <= {sdaIn, sdaMeta, sdaSync};
      {tglMeta, tglSync, tglPrev} <= {linkToggle_q, tglMeta, tglSync};
    end
  end

  // bus events seen in the system domain
  logic sclFall, riseEvt, busStart, busStop, eighthFall, ninthFall;
  assign sclFall    = sclPrev & ~sclSync;
  assign riseEvt    = tglSync ^ tglPrev;  // linkBit_q stable by now
  assign busStart   = sdaPrev & ~sdaSync & sclSync & sclPrev;
  assign busStop    = ~sdaPrev & sdaSync & sclSync & sclPrev;
  assign eighthFall = sclFall & (cnt_q == tcss_pkg::BYTE_BITS);
  assign ninthFall  = sclFall & (cnt_q == tcss_pkg::ACK_BIT);

  // address compare and decoded events
  logic inAddr, inLow, inRx, inTx;
  logic addrMatch, lowMatch, addrDone, lowDone, rxDone, holdNow;
  logic ackValue, ackGiven, ackEnd, txEnd, lowEnd, toAddrLow;
  logic stretchAfterAck, irqSet, relClr, uaSet, bfSet, bfClr;
  logic txAccept, ownAccept;
  assign inAddr    = (phase_q == tcss_pkg::PH_ADDR);
  assign inLow     = (phase_q == tcss_pkg::PH_ADDR_LOW);
  assign inRx      = (phase_q == tcss_pkg::PH_RX);
  assign inTx      = (phase_q == tcss_pkg::PH_TX);
  // a ten-bit read header only matches once fully addressed
  assign addrMatch = inAddr & (shift_q[7:1] == ownAddr_q[7:1])
                     & (~ctrl.tenBitMode | ~shift_q[0] | tenMatched_q);
  assign lowMatch  = inLow & (shift_q == ownAddr_q);
  assign addrDone  = eighthFall & addrMatch;
  assign lowDone   = eighthFall & lowMatch;
  assign rxDone    = eighthFall & inRx;
  // extra hold after eighth fall, same for both widths
  assign holdNow   = ((addrDone | lowDone) & ctrl.addressHoldEnable)
                     | (rxDone & ctrl.dataHoldEnable);
  // ack value comes from software only when held
  assign ackValue  = ackUsesSw_q ? ctrl.ackDataValue : 1'h0;
  assign ackGiven  = ackWindow_q & ~ackValue;
  assign ackEnd    = ninthFall & ackGiven & (inAddr | inLow | inRx);
  assign txEnd     = ninthFall & inTx;
  assign lowEnd    = ninthFall & inLow;
  // a ten-bit write header always asks for the low byte again
  assign toAddrLow = inAddr & ctrl.tenBitMode & ~rw_q;
  // stretch after ack: always for reads, else on stretch enable except after a ten-bit write header
  assign stretchAfterAck = ackEnd & ((inAddr & rw_q)
                           | (ctrl.stretchEnable & ~toAddrLow));
  assign irqSet    = (busStart & ctrl.startIrqEnable)
                     | holdNow | ackEnd | lowEnd | txEnd;
  assign relClr    = holdNow | stretchAfterAck | (txEnd & ~ackRx_q);
  assign uaSet     = (ackEnd & toAddrLow) | lowEnd;
  assign txAccept  = txLoad & inTx & (cnt_q == 4'h0) & ~ackWindow_q;
  assign bfSet     = addrDone | lowDone | rxDone | txAccept;
  assign bfClr     = bufferRead | (eighthFall & inTx);
  assign ownAccept = ownAddrWrite & ~ackWindow_q;

  // transfer phase sequencing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= tcss_pkg::PH_IDLE;
    end else if (busStart) begin
      phase_q <= tcss_pkg::PH_ADDR;
    end else if (busStop) begin
      phase_q <= tcss_pkg::PH_IDLE;
    end else if (ninthFall) begin
      case (phase_q)
        tcss_pkg::PH_ADDR: begin
          if (!ackGiven) begin
            phase_q <= tcss_pkg::PH_IDLE;
          end else if (rw_q) begin
            phase_q <= tcss_pkg::PH_TX;
          end else if (toAddrLow) begin
            phase_q <= tcss_pkg::PH_ADDR_LOW;
          end else begin
            phase_q <= tcss_pkg::PH_RX;
          end
        end
        tcss_pkg::PH_ADDR_LOW: begin
          phase_q <= ackGiven ? tcss_pkg::PH_RX : tcss_pkg::PH_IDLE;
        end
        tcss_pkg::PH_RX: begin
          phase_q <= ackGiven ? tcss_pkg::PH_RX : tcss_pkg::PH_IDLE;
        end
        tcss_pkg::PH_TX: begin
          // nack from controller ends the read
          phase_q <= ackRx_q ? tcss_pkg::PH_IDLE : tcss_pkg::PH_TX;
        end
        default: begin
          phase_q <= tcss_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // bit counter and receive shift register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q   <= 4'h0;
      shift_q <= tcss_pkg::BYTE_RESET;
    end else if (busStart || ninthFall) begin
      cnt_q <= 4'h0;
    end else if (riseEvt && cnt_q != tcss_pkg::ACK_BIT) begin
      cnt_q   <= cnt_q + 4'h1;
      shift_q <= {shift_q[6:0], linkBit_q};
    end
  end

  // ten-bit address progress, kept across a restart
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tenMatched_q <= 1'h0;
    end else if (busStop) begin
      tenMatched_q <= 1'h0;
    end else if (lowEnd) begin
      tenMatched_q <= ackGiven; // low mismatch forgets the match
    end
  end

  // ack slot ownership, opened at the eighth fall
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ackWindow_q <= 1'h0;
      ackUsesSw_q <= 1'h0;
    end else if (busStart || busStop || ninthFall) begin
      ackWindow_q <= 1'h0;
    end else if (addrDone || lowDone || rxDone) begin
      ackWindow_q <= 1'h1;
      ackUsesSw_q <= rxDone ? ctrl.dataHoldEnable : ctrl.addressHoldEnable;
    end
  end

  // transmit shifter: loaded by software, shifted on scl falls
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txShift_q <= tcss_pkg::BYTE_RESET;
      txValid_q <= 1'h0;
    end else if (busStart || busStop || (eighthFall && inTx)) begin
      txValid_q <= 1'h0;
    end else if (txAccept) begin
      txShift_q <= txData;
      txValid_q <= 1'h1;
    end else if (sclFall && inTx && cnt_q != 4'h0) begin
      txShift_q <= {txShift_q[6:0], 1'h0};
    end
  end

  // controller acknowledge sampled at the ninth rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ackRx_q <= 1'h0;
    end else if (riseEvt && inTx && cnt_q == tcss_pkg::BYTE_BITS) begin
      ackRx_q <= linkBit_q;
    end
  end

  // interrupt flag: a new event wins over a clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= irqSet | (irq_q & ~irqClear);
    end
  end

  // clock release bit: a hardware clear wins over a set
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rel_q <= tcss_pkg::CLOCK_RELEASE_INIT;
    end else if (relClr) begin
      rel_q <= 1'h0;
    end else if (releaseSet) begin
      rel_q <= 1'h1;
    end
  end

  // buffer full: set by a byte, cleared by a read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bf_q <= 1'h0;
    end else begin
      bf_q <= bfSet | (bf_q & ~bfClr);
    end
  end

  // update-address flag, cleared by an own-address write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ua_q <= 1'h0;
    end else begin
      ua_q <= uaSet | (ua_q & ~ownAccept);
    end
  end

  // own address register and received byte
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ownAddr_q <= tcss_pkg::OWN_ADDR_RESET;
      rxData_q  <= tcss_pkg::BYTE_RESET;
    end else begin
      if (ownAccept) begin
        ownAddr_q <= ownAddrData;
      end
      if (addrDone || lowDone || rxDone) begin
        rxData_q <= shift_q;
      end
    end
  end

  // source-of-interrupt status bits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_timing_status_q <= 1'h0;
      rw_q     <= 1'h0;
      dna_q    <= 1'h0;
    end else begin
      if (holdNow) begin
        ack_timing_status_q <= 1'h1;
      end else if (ninthFall) begin
        ack_timing_status_q <= 1'h0;
      end
      if (addrDone) begin
        rw_q <= shift_q[0];
      end
      if (addrDone || lowDone) begin
        dna_q <= 1'h0;
      end else if (rxDone) begin
        dna_q <= 1'h1;
      end
    end
  end

  // start and stop status
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      startSeen_q <= 1'h0;
      stopSeen_q  <= 1'h0;
    end else if (busStart) begin
      startSeen_q <= 1'h1;
      stopSeen_q  <= 1'h0;
    end else if (busStop) begin
      startSeen_q <= 1'h0;
      stopSeen_q  <= 1'h1;
    end
  end

  // pin pulls: hold scl once it is low, drive ack or data low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclPull_q <= 1'h0;
      sdaPull_q <= 1'h0;
    end else begin
      if ((!rel_q || ua_q) && !sclSync) begin
        sclPull_q <= 1'h1;
      end else if (rel_q && !ua_q) begin
        sclPull_q <= 1'h0;
      end
      sdaPull_q <= (ackWindow_q & ~ackValue)
                   | (inTx & txValid_q & ~txShift_q[7]); // last bit held to eighth fall
    end
  end

  // output pin flops, only ever a low pull
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclOut  <= 1'h0;
      sdaOut  <= 1'h0;
      sclOe_n <= 1'h1;
      sdaOe_n <= 1'h1;
    end else begin
      sclOut  <= 1'h0;
      sdaOut  <= 1'h0;
      sclOe_n <= ~sclPull_q;
      sdaOe_n <= ~sdaPull_q;
    end
  end

  // status wiring straight from flops
  assign status = '{serialIrqFlag:     irq_q,
                    clockReleaseBit:   rel_q,
                    bufferFullFlag:    bf_q,
                    updateAddressFlag: ua_q,
                    ackTimingStatus:   ack_timing_status_q,
                    ackReceivedStatus: ackRx_q,
                    readNotWrite:      rw_q,
                    dataNotAddress:    dna_q,
                    startSeen:         startSeen_q,
                    stopSeen:          stopSeen_q};
  assign rxData     = rxData_q;
  assign ownAddress = ownAddr_q;

  // checks in the system domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_start_irq: assert property (busStart && ctrl.startIrqEnable |=> irq_q && startSeen_q)
    else $error("start did not raise irq");
  a_addr_hold: assert property (addrDone && ctrl.addressHoldEnable
    |=> !rel_q && irq_q && ack_timing_status_q)
    else $error("address hold not applied");
  a_read_stretch: assert property (ackEnd && inAddr && rw_q
    |=> !rel_q && inTx ##1 sclPull_q)
    else $error("read address did not stretch");
  a_ack_capture: assert property (riseEvt && inTx && cnt_q == 4'h8
    |=> ackRx_q == $past(linkBit_q))
    else $error("controller ack not captured");
  a_nack_idle: assert property (txEnd && ackRx_q |=> phase_q == tcss_pkg::PH_IDLE)
    else $error("nack did not end read");
  a_tx_irq: assert property (txEnd |=> irq_q)
    else $error("transmit byte gave no irq");
  a_ten_update: assert property (ackEnd && toAddrLow |=> ua_q && inLow)
    else $error("high byte did not set update flag");
  a_low_miss: assert property (lowEnd && !ackGiven |=> irq_q && ua_q && !inRx)
    else $error("low mismatch handled wrongly");
  a_addr_block: assert property (ownAddrWrite && ackWindow_q
    |=> ownAddr_q == $past(ownAddr_q))
    else $error("own address written during ack");
  a_ua_release: assert property (ua_q && rel_q && ownAddrWrite && !ackWindow_q && !uaSet
    |=> !ua_q ##1 !sclPull_q)
    else $error("own address write did not release");
  a_data_hold: assert property (rxDone && ctrl.dataHoldEnable |=> !rel_q && dna_q)
    else $error("data hold not applied");
  a_buf_read: assert property (bufferRead && !bfSet |=> !bf_q)
    else $error("read did not clear full flag");
  a_scl_wait: assert property (!rel_q && !relClr && !sclSync |=> sclPull_q ##1 !sclOe_n)
    else $error("scl not held after release clear");

  c_read_byte: cover property (txEnd && !ackRx_q);
  c_ten_bit: cover property (ackEnd && inLow);
  c_data_hold: cover property (rxDone && ctrl.dataHoldEnable);
  c_start: cover property (busStart);

endmodule
`default_nettype wire

// ### hdl/tcss_pkg.sv
// Notes on behaviour
// - address hold: release cleared, irq after eighth fall
// - start sets status; irq only if enabled
// - held address acknowledge uses software ack value
// - read address acked: release cleared, irq set
// - transmit load only after ack; sets full
// - controller ack captured on ninth rising edge
// - controller nack: stop holding, go idle
// - ten-bit high write byte: ack, update flag, irq
// - own-address write releases clock line held only by update flag
// - own-address writes blocked during ack sequence
// - low mismatch: irq and update flag only
// - own address reloadable with high byte later
// - received data acked: irq, optional stretch
// - release clear: wait scl low, then hold
// - stretch enable: stretch after every acknowledge except a ten-bit high write byte
// - update flag holds clock, release bit untouched
// - data hold: release cleared after eighth fall
// - buffer read clears the full flag
// - ack timing, direction, data/address status shown
// - ten-bit hold points match seven-bit ones
// - transmit irq on ninth falling edge
package tcss_pkg;
  // bit counts within one byte frame
  localparam logic [3:0] BYTE_BITS          = 4'h8;
  localparam logic [3:0] ACK_BIT            = 4'h9;
  // values after reset
  localparam logic [7:0] OWN_ADDR_RESET     = 8'h00;
  localparam logic       CLOCK_RELEASE_INIT = 1'h1;
  localparam logic [7:0] BYTE_RESET         = 8'h00;

  // transfer phase of the target
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ADDR_LOW,
    PH_RX,
    PH_TX
  } tcss_phase_t;

  // software control bits
  typedef struct packed {
    logic addressHoldEnable;
    logic dataHoldEnable;
    logic stretchEnable;
    logic tenBitMode;
    logic startIrqEnable;
    logic ackDataValue;
  } tcss_ctrl_t;

  // software visible status bits
  typedef struct packed {
    logic serialIrqFlag;
    logic clockReleaseBit;
    logic bufferFullFlag;
    logic updateAddressFlag;
    logic ackTimingStatus;
    logic ackReceivedStatus;
    logic readNotWrite;
    logic dataNotAddress;
    logic startSeen;
    logic stopSeen;
  } tcss_status_t;
endpackage

// ### sim/tcss_bus_ctl.sv
`timescale 1ns/1ns
`default_nettype none
// bus controller model: makes scl, drives sda, both open drain
module tcss_bus_ctl (
  // resolved wire levels
  input  wire logic sclWire,
  input  wire logic sdaWire,
  // controller pulls, 1 = released to the pull-up
  output var logic  ctlScl,
  output var logic  ctlSda
);
  int hangs; // stretches that never ended

  // lines released while idle
  initial begin
    ctlScl = 1'b1;
    ctlSda = 1'b1;
    hangs  = 0;
  end

  // one bit: data set while scl low, sampled late in the high time
  task automatic bitIo(input logic v, output logic s);
    int n;
    n = 0;
    #15 ctlSda = v;
    #47 ctlScl = 1'b1;
    // target may stretch, bounded wait
    while (sclWire !== 1'b1 && n < 8000) begin
      #1 n++;
    end
    if (n >= 8000) begin
      hangs++;
    end
    #40 s = sdaWire;
    #23 ctlScl = 1'b0;
  endtask

  // start or restart: sda falls while scl high
  task automatic start();
    #15 ctlSda = 1'b1;
    #47 ctlScl = 1'b1;
    #62 ctlSda = 1'b0;
    #62 ctlScl = 1'b0;
  endtask

  // stop: sda rises while scl high, then lines stand still
  task automatic stop();
    #15 ctlSda = 1'b0;
    #47 ctlScl = 1'b1;
    #62 ctlSda = 1'b1;
    #62;
  endtask

  // byte to the target, msb first, then target ack
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], s);
    end
    bitIo(1'b1, ack);
  endtask

  // byte from the target; last byte is answered with nack
  task automatic readByte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, b[i]);
    end
    bitIo(nack, s);
  endtask
endmodule
`default_nettype wire

// ### sim/tcss_target_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// testbench: software side driven here, bus side by the controller model
module tcss_target_tb_top;
  typedef struct packed {
    logic       sie;
    logic [7:0] own;
    logic [7:0] addr;
    logic [7:0] data;
    logic       ack;
  } tcss_row_t;
  localparam logic [2:0] SW_REL = 3'h0; // strobe selectors
  localparam logic [2:0] SW_IRQ = 3'h1;
  localparam logic [2:0] SW_RD  = 3'h2;
  localparam logic [2:0] SW_TX  = 3'h3;
  localparam logic [2:0] SW_OWN = 3'h4;
  logic clock, reset_n, sclWire, sdaWire, ctlScl, ctlSda;
  logic sclOut, sclOe_n, sdaOut, sdaOe_n;
  logic releaseSet, irqClear, bufferRead, txLoad, ownAddrWrite;
  logic [7:0] txData, ownAddrData, rxData, ownAddress, b;
  logic a;
  tcss_pkg::tcss_ctrl_t   ctrl;
  tcss_pkg::tcss_status_t status;
  int errors, testsRun;
  // plain cases: start irq enable, own address, address, data, expected ack
  tcss_row_t rows [3] = '{'{1'b1, 8'h42, 8'h42, 8'h5c, 1'b0},
                          '{1'b0, 8'h42, 8'h44, 8'h5c, 1'b1},
                          '{1'b0, 8'hfe, 8'hfe, 8'ha3, 1'b0}};

  // wired-and bus with pull-ups
  assign sclWire = ctlScl & (sclOe_n | sclOut);
  assign sdaWire = ctlSda & (sdaOe_n | sdaOut);

  // 250 MHz system clock
  always begin
    #2 clock = ~clock;
  end

  tcss_bus_ctl i_ctl (.sclWire(sclWire), .sdaWire(sdaWire), .ctlScl(ctlScl), .ctlSda(ctlSda));

  tcss_target #(.BYTE_WIDTH(8)) i_dut (
    .clock(clock), .reset_n(reset_n), .linkClock(sclWire), .sclIn(sclWire),
    .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .ctrl(ctrl), .releaseSet(releaseSet), .irqClear(irqClear),
    .bufferRead(bufferRead), .txLoad(txLoad), .txData(txData),
    .ownAddrWrite(ownAddrWrite), .ownAddrData(ownAddrData), .status(status),
    .rxData(rxData), .ownAddress(ownAddress));

  // verdict and end of run
  task automatic final_report();
    errors += i_ctl.hangs;
    $display("checks %0d errors %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // byte compare
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // single bit compare
  task automatic chk1(input string nm, input logic e, input logic g);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  // one software strobe, driven at the rising edge
  task automatic sw(input logic [2:0] k, input logic [7:0] d);
    @(posedge clock);
    case (k)
      SW_REL: releaseSet <= 1'b1;
      SW_IRQ: irqClear <= 1'b1;
      SW_RD:  bufferRead <= 1'b1;
      SW_TX: begin
        txLoad <= 1'b1;
        txData <= d;
      end
      default: begin
        ownAddrWrite <= 1'b1;
        ownAddrData  <= d;
      end
    endcase
    @(posedge clock);
    {releaseSet, irqClear, bufferRead, txLoad, ownAddrWrite} <= 5'h00;
    repeat (3) @(posedge clock);
  endtask

  // let flags and pin enables land, sample away from the edge
  task automatic settle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  // bounded wait for the release bit to drop
  task automatic waitRel();
    int n;
    n = 0;
    while (status.clockReleaseBit !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("[ERR] release bit wait timed out");
      final_report();
    end
    settle();
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    ctrl = tcss_pkg::tcss_ctrl_t'(6'h00);
    {releaseSet, irqClear, bufferRead, txLoad, ownAddrWrite} = 5'h00;
    txData = 8'h00;
    ownAddrData = 8'h00;
    errors = 0;
    testsRun = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    chk1("release at reset", tcss_pkg::CLOCK_RELEASE_INIT, status.clockReleaseBit);
    chk1("scl free at reset", 1'b1, sclOe_n);
    chk1("sda free at reset", 1'b1, sdaOe_n);
    chk1("pins low only", 1'b0, sclOut | sdaOut);
    chk8("own at reset", tcss_pkg::OWN_ADDR_RESET, ownAddress);
    // plain seven-bit writes, no holds
    foreach (rows[i]) begin
      @(posedge clock);
      ctrl <= tcss_pkg::tcss_ctrl_t'({4'h0, rows[i].sie, 1'b0});
      sw(SW_OWN, rows[i].own);
      i_ctl.start();
      settle();
      chk1("start seen", 1'b1, status.startSeen);
      chk1("start irq", rows[i].sie, status.serialIrqFlag);
      sw(SW_IRQ, 8'h00);
      i_ctl.writeByte(rows[i].addr, a);
      settle();
      chk1("addr ack", rows[i].ack, a);
      if (!rows[i].ack) chk8("addr byte", rows[i].addr, rxData);
      sw(SW_RD, 8'h00);
      settle();
      chk1("full cleared", 1'b0, status.bufferFullFlag);
      sw(SW_IRQ, 8'h00);
      i_ctl.writeByte(rows[i].data, a);
      settle();
      chk1("data ack", rows[i].ack, a);
      chk1("data irq", ~rows[i].ack, status.serialIrqFlag);
      if (!rows[i].ack) chk1("data flag", 1'b1, status.dataNotAddress);
      i_ctl.stop();
      sw(SW_RD, 8'h00);
      chk1("stop seen", 1'b1, status.stopSeen);
      sw(SW_IRQ, 8'h00);
    end
    // read with address hold: early loads refused, nack ends the hold
    @(posedge clock);
    ctrl <= tcss_pkg::tcss_ctrl_t'(6'h20);
    sw(SW_OWN, 8'h42);
    i_ctl.start();
    fork
      i_ctl.writeByte(8'h43, a);
      begin
        waitRel();
        chk1("hold irq", 1'b1, status.serialIrqFlag);
        chk1("ack timing", 1'b1, status.ackTimingStatus);
        chk1("scl held", 1'b0, sclOe_n);
        sw(SW_OWN, 8'h55);
        sw(SW_RD, 8'h00);
        sw(SW_TX, 8'h99);
        settle();
        chk8("own locked", 8'h42, ownAddress);
        chk1("early load", 1'b0, status.bufferFullFlag);
        sw(SW_IRQ, 8'h00);
        sw(SW_REL, 8'h00);
      end
    join
    chk1("held addr ack", 1'b0, a);
    waitRel();
    chk1("read irq", 1'b1, status.serialIrqFlag);
    chk1("read dir", 1'b1, status.readNotWrite);
    sw(SW_IRQ, 8'h00);
    sw(SW_TX, 8'ha5);
    settle();
    chk1("load full", 1'b1, status.bufferFullFlag);
    fork
      i_ctl.readByte(1'b0, b);
      sw(SW_REL, 8'h00);
    join
    settle();
    chk8("tx byte", 8'ha5, b);
    chk1("ctl ack", 1'b0, status.ackReceivedStatus);
    chk1("tx irq", 1'b1, status.serialIrqFlag);
    waitRel();
    sw(SW_IRQ, 8'h00);
    sw(SW_TX, 8'h3c);
    fork
      i_ctl.readByte(1'b1, b);
      sw(SW_REL, 8'h00);
    join
    settle();
    chk8("last tx byte", 8'h3c, b);
    chk1("ctl nack", 1'b1, status.ackReceivedStatus);
    chk1("last irq", 1'b1, status.serialIrqFlag);
    chk1("scl let go", 1'b1, sclOe_n);
    chk1("sda let go", 1'b1, sdaOe_n);
    i_ctl.stop();
    // write with stretch and data hold
    @(posedge clock);
    ctrl <= tcss_pkg::tcss_ctrl_t'(6'h18);
    sw(SW_IRQ, 8'h00);
    i_ctl.start();
    i_ctl.writeByte(8'h42, a);
    waitRel();
    chk1("stretch addr", 1'b0, sclOe_n);
    sw(SW_RD, 8'h00);
    sw(SW_REL, 8'h00);
    fork
      i_ctl.writeByte(8'h6e, a);
      begin
        waitRel();
        chk1("data hold timing", 1'b1, status.ackTimingStatus);
        chk8("held data", 8'h6e, rxData);
        sw(SW_RD, 8'h00);
        sw(SW_REL, 8'h00);
        waitRel();
        chk1("after ack timing", 1'b0, status.ackTimingStatus);
        chk1("stretch data", 1'b0, sclOe_n);
      end
    join
    chk1("held data ack", 1'b0, a);
    sw(SW_REL, 8'h00);
    i_ctl.stop();
    // ten-bit address: update flag holds scl, own writes release it
    @(posedge clock);
    ctrl <= tcss_pkg::tcss_ctrl_t'(6'h04);
    sw(SW_OWN, 8'hf2);
    sw(SW_IRQ, 8'h00);
    i_ctl.start();
    i_ctl.writeByte(8'hf2, a);
    settle();
    chk1("high ack", 1'b0, a);
    chk1("high update", 1'b1, status.updateAddressFlag);
    chk1("high irq", 1'b1, status.serialIrqFlag);
    chk1("update holds", 1'b0, sclOe_n);
    chk1("release kept", 1'b1, status.clockReleaseBit);
    sw(SW_RD, 8'h00);
    sw(SW_IRQ, 8'h00);
    fork
      i_ctl.writeByte(8'h37, a);
      begin
        sw(SW_OWN, 8'h37);
        settle();
        chk1("own write frees", 1'b1, sclOe_n);
      end
    join
    settle();
    chk1("low ack", 1'b0, a);
    chk1("low update", 1'b1, status.updateAddressFlag);
    sw(SW_OWN, 8'hf2);
    settle();
    chk8("own reloaded", 8'hf2, ownAddress);
    sw(SW_RD, 8'h00);
    sw(SW_IRQ, 8'h00);
    i_ctl.start();
    i_ctl.writeByte(8'hf2, a);
    sw(SW_RD, 8'h00);
    sw(SW_IRQ, 8'h00);
    fork
      i_ctl.writeByte(8'h38, a);
      sw(SW_OWN, 8'h37);
    join
    settle();
    chk1("low mismatch ack", 1'b1, a);
    chk1("mismatch irq", 1'b1, status.serialIrqFlag);
    chk1("mismatch update", 1'b1, status.updateAddressFlag);
    chk1("mismatch full", 1'b0, status.bufferFullFlag);
    chk1("mismatch release", 1'b1, status.clockReleaseBit);
    sw(SW_OWN, 8'hf2);
    settle();
    chk1("reload frees", 1'b1, sclOe_n);
    i_ctl.stop();
    final_report();
  end
endmodule
`default_nettype wire
